//--- src/sacc_top.sv
// Summary of operation
// RQ1: 240 s store, default eight 30 s cells
// RQ2: Cell count 1,2,4,8,16,30,60, equal shares
// RQ3: Recording ends after 2 s continuous silence
// RQ4: Recording ends when the cell is full
// RQ5: DTR off: bytes forwarded, never decoded
// RQ6: DTR on: bytes decoded as instructions
// RQ7: Each received byte is one whole instruction
// RQ8: Answers are single bytes on host port
// RQ9: Cell plays once or a repeated count
// RQ10: Six independent speaker select outputs
// RQ11: Output fed by playback or external input
// RQ12: Play, repeat, stop, output, cells, record, status, speakers
// RQ13: Sent twice unless playing; matched pair executes
// RQ14: Host link 9600 baud, one stop, no parity
// RQ15: 01 plays, 10 records, low six bits cell
// RQ16: Status answers four bytes
// RQ17: Unknown codes are ignored
// RQ18: Cell count changes only when idle
`timescale 1ns/1ps
`default_nettype none
module sacc_top import sacc_pkg::*; #(
    parameter int SEC_CYC = SEC_CYCLES,
    parameter int SIL_CYC = SILENCE_CYCLES,
    parameter int PAIR_CYC = PAIR_CYCLES,
    parameter int BIT_CYC = BIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic host_rxd,
    input wire logic host_dtr,
    output logic host_txd,
    output logic passthrough_txd,
    input wire logic audio_present,
    output logic [5:0] speaker_sel,
    output logic play_active,
    output logic record_active,
    output logic out_ext_sel,
    output logic [5:0] active_cell
);
    // ****************************************************
    // Serial ends
    // ****************************************************
    logic [7:0] rx_byte;
    logic rx_valid;
    logic tx_start;
    logic tx_busy;
    logic [7:0] tx_data;

    sacc_uart_rx #(.CYC(BIT_CYC)) sacc_uart_rx_inst (
        .clk(pclk),
        .rst_n(presetn),
        .rxd(host_rxd),
        .data(rx_byte),
        .valid(rx_valid)
    );
    sacc_uart_tx #(.CYC(BIT_CYC)) sacc_uart_tx_inst (
        .clk(pclk),
        .rst_n(presetn),
        .start(tx_start),
        .data(tx_data),
        .busy(tx_busy),
        .txd(host_txd)
    );

    // Idle high while DTR is on so the printer sees no noise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) passthrough_txd <= 1'b1;
        else passthrough_txd <= host_dtr ? 1'b1 : host_rxd; // [RQ5]
    end

    // ****************************************************
    // Pair check
    // ****************************************************
    sacc_mode_type mode;
    logic cmd_en;
    logic have_first;
    logic [7:0] first_byte;
    logic [31:0] pair_tmr;
    logic byte_in;
    logic cmd_go;
    logic mism;
    logic tmo;

    assign byte_in = rx_valid && host_dtr && cmd_en; // [RQ5] [RQ6]
    assign tmo = have_first && !byte_in && pair_tmr == 32'h0;

    always_comb begin
        cmd_go = 1'b0;
        mism = 1'b0;
        if (byte_in) begin
            if (mode == MODE_PLAY) cmd_go = 1'b1; // [RQ13]
            else if (have_first && rx_byte == first_byte) cmd_go = 1'b1; // [RQ13]
            else if (have_first) mism = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            have_first <= 1'b0;
            first_byte <= 8'h00;
            pair_tmr <= 32'h0;
        end else if (byte_in && mode != MODE_PLAY && !have_first) begin
            have_first <= 1'b1;
            first_byte <= rx_byte;
            pair_tmr <= 32'(PAIR_CYC - 1);
        end else if (byte_in || tmo) begin
            have_first <= 1'b0;
        end else if (have_first) begin
            pair_tmr <= pair_tmr - 32'h1;
        end
    end

    // ****************************************************
    // Decode
    // ****************************************************
    logic [6:0] cells;
    logic [5:0] cell_no;
    logic cell_ok;
    logic is_play, is_rec, is_spk, is_rep, is_cfg, is_stat, is_stop, is_on, is_off, cmd_ok;
    logic [6:0] cfg_val;

    assign cell_no = rx_byte[5:0]; // [RQ15]
    assign cell_ok = cell_no != 6'h00 && {1'b0, cell_no} <= cells;
    assign is_stat = rx_byte == OP_STATUS; // [RQ16]
    assign is_play = rx_byte[7:6] == 2'b01 && cell_ok && mode != MODE_REC; // [RQ15]
    assign is_rec = rx_byte[7:6] == 2'b10 && cell_ok && mode == MODE_IDLE; // [RQ15]
    assign is_spk = rx_byte[7:6] == 2'b11;
    assign is_rep = rx_byte[7:5] == 3'b001 && rx_byte[4:0] != 5'h00 && mode == MODE_PLAY;
    assign is_stop = rx_byte == OP_STOP;
    assign is_on = rx_byte == OP_EXT_ON;
    assign is_off = rx_byte == OP_EXT_OFF;
    assign cfg_val = rx_byte == OP_ONE_CELL ? 7'h01 : {rx_byte[5:0], 1'b0}; // [RQ2]
    assign is_cfg = mode == MODE_IDLE && (rx_byte == OP_ONE_CELL || (rx_byte[7:5] == 3'b000 &&
        (rx_byte[4:0] inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h0F, 5'h1E}))); // [RQ2] [RQ18]
    // Whole byte decoded at once; anything else leaves state alone [RQ7] [RQ12] [RQ17]
    assign cmd_ok = is_stat || is_play || is_rec || is_spk || is_rep || is_stop ||
        is_on || is_off || is_cfg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cells <= DEF_CELLS; // [RQ1]
        else if (cmd_go && is_cfg) cells <= cfg_val; // [RQ2] [RQ18]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) speaker_sel <= 6'h00;
        else if (cmd_go && is_spk) speaker_sel <= rx_byte[5:0]; // [RQ10]
    end

    // ****************************************************
    // Record and play
    // ****************************************************
    logic [31:0] sec_cnt;
    logic [31:0] sil_cnt;
    logic [7:0] elapsed;
    logic [7:0] cap;
    logic [4:0] rep_left;
    logic [7:0] rec_len [64];
    logic ext_en;
    logic tick, full, rec_end, play_hit, play_end;

    function automatic logic [7:0] cap_of(input logic [6:0] c);
        case (c)
            7'h01: cap_of = 8'(STORE_SEC / 1);
            7'h02: cap_of = 8'(STORE_SEC / 2);
            7'h04: cap_of = 8'(STORE_SEC / 4);
            7'h08: cap_of = 8'(STORE_SEC / 8);
            7'h10: cap_of = 8'(STORE_SEC / 16);
            7'h1E: cap_of = 8'(STORE_SEC / 30);
            default: cap_of = 8'(STORE_SEC / 60);
        endcase
    endfunction

    assign cap = cap_of(cells); // [RQ1] [RQ2]
    assign tick = sec_cnt == 32'(SEC_CYC - 1);
    assign full = tick && elapsed + 8'h01 == cap; // [RQ4]
    assign rec_end = mode == MODE_REC && (full || sil_cnt == 32'(SIL_CYC - 1)); // [RQ3] [RQ4]
    assign play_hit = mode == MODE_PLAY && elapsed == rec_len[active_cell];
    assign play_end = play_hit && rep_left == 5'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_IDLE;
            active_cell <= 6'h00;
            sec_cnt <= 32'h0;
            elapsed <= 8'h00;
        end else if (cmd_go && (is_rec || is_play)) begin
            mode <= is_rec ? MODE_REC : MODE_PLAY; // [RQ9] [RQ15]
            active_cell <= cell_no;
            sec_cnt <= 32'h0;
            elapsed <= 8'h00;
        end else if (cmd_go && mode == MODE_PLAY && (is_stop || is_on || is_off)) begin
            mode <= MODE_IDLE;
        end else if (rec_end || play_end) begin
            mode <= MODE_IDLE; // [RQ3] [RQ4]
        end else if (play_hit) begin
            sec_cnt <= 32'h0;
            elapsed <= 8'h00; // [RQ9]
        end else if (mode != MODE_IDLE) begin
            sec_cnt <= tick ? 32'h0 : sec_cnt + 32'h1;
            if (tick) elapsed <= elapsed + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rep_left <= 5'h00;
        else if (cmd_go && is_play) rep_left <= 5'h00;
        else if (cmd_go && is_rep) rep_left <= rx_byte[4:0]; // [RQ9]
        else if (play_hit && rep_left != 5'h00) rep_left <= rep_left - 5'h01;
    end

    // Any sound restarts the silence window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sil_cnt <= 32'h0;
        else if (mode != MODE_REC || audio_present) sil_cnt <= 32'h0;
        else sil_cnt <= sil_cnt + 32'h1; // [RQ3]
    end

    // Length kept in whole seconds; trailing silence is part of it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 64; i++) rec_len[i] <= 8'h00;
        end else if (rec_end) begin
            rec_len[active_cell] <= full ? cap : elapsed; // [RQ4]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ext_en <= 1'b0;
        else if (cmd_go && is_on) ext_en <= 1'b1; // [RQ11]
        else if (cmd_go && (is_off || is_play)) ext_en <= 1'b0; // [RQ11]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            play_active <= 1'b0;
            record_active <= 1'b0;
            out_ext_sel <= 1'b0;
        end else begin
            play_active <= mode == MODE_PLAY; // [RQ11]
            record_active <= mode == MODE_REC;
            out_ext_sel <= ext_en; // [RQ11]
        end
    end

    // ****************************************************
    // Answers
    // ****************************************************
    logic [6:0] pend;
    logic [6:0] ev;
    logic [6:0] gnt;
    logic [7:0] ack_byte;
    logic [7:0] resp [4];
    logic [2:0] resp_n;

    assign ev = {tmo, mism, play_end, rec_end, cmd_go && is_play,
        cmd_go && cmd_ok && !is_stat, cmd_go && is_stat};
    assign gnt = resp_n == 3'h0 ? (pend & (~pend + 7'h01)) : 7'h00;
    assign tx_start = resp_n != 3'h0 && !tx_busy;
    assign tx_data = resp[0];

    // New event wins over the grant that clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 7'h00;
            ack_byte <= 8'h00;
        end else begin
            pend <= (pend & ~gnt) | ev;
            if (ev[1]) ack_byte <= rx_byte; // [RQ13]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) resp[i] <= 8'h00;
            resp_n <= 3'h0;
        end else if (gnt[0]) begin
            resp[0] <= OP_STATUS; // [RQ16]
            resp[1] <= {ext_en, mode == MODE_PLAY, speaker_sel}; // [RQ16]
            resp[2] <= {1'b0, cells};
            resp[3] <= mode == MODE_PLAY ? {2'b00, active_cell} : 8'h00;
            resp_n <= 3'h4;
        end else if (gnt != 7'h00) begin
            unique case (1'b1)
                gnt[1]: resp[0] <= ack_byte;
                gnt[2]: resp[0] <= RSP_PLAY_START;
                gnt[3]: resp[0] <= RSP_REC_DONE;
                gnt[4]: resp[0] <= RSP_PLAY_DONE;
                gnt[5]: resp[0] <= RSP_MISMATCH;
                gnt[6]: resp[0] <= RSP_TIMEOUT;
            endcase
            resp_n <= 3'h1; // [RQ8]
        end else if (tx_start) begin
            for (int i = 0; i < 3; i++) resp[i] <= resp[i + 1];
            resp_n <= resp_n - 3'h1;
        end
    end

    // ****************************************************
    // APB registers and interrupt
    // ****************************************************
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_ev;
    logic wr;

    assign wr = psel && penable && pready && pwrite;
    assign irq_ev = {mism || tmo, play_end, rec_end, cmd_go && cmd_ok};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr inside {OFS_CTRL, OFS_STATE,
                OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN});
            prdata <= 32'h0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    OFS_CTRL: prdata <= {31'h0, cmd_en};
                    OFS_STATE: prdata <= {9'h0, cells, 1'b0, record_active, active_cell,
                        out_ext_sel, play_active, speaker_sel};
                    OFS_IRQ_STAT: prdata <= {28'h0, irq_stat};
                    OFS_IRQ_EN: prdata <= {28'h0, irq_en};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_en <= CTRL_RST;
            irq_en <= '0;
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            if (wr && paddr == OFS_CTRL) cmd_en <= pwdata[0];
            if (wr && paddr == OFS_IRQ_EN) irq_en <= pwdata[IRQ_W-1:0];
            irq_stat <= (irq_stat & ~((wr && paddr == OFS_IRQ_CLR) ?
                pwdata[IRQ_W-1:0] : '0)) | irq_ev;
            irq <= |(irq_stat & irq_en);
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fwd_bytes_a: assert property (!host_dtr |=> passthrough_txd == $past(host_rxd)) // [RQ5]
        else $error("passthrough not following host line");
    no_decode_a: assert property (rx_valid && !host_dtr |-> !cmd_go && !have_first) // [RQ5]
        else $error("byte decoded with DTR off");
    dtr_exec_a: assert property (cmd_go |-> host_dtr && rx_valid) // [RQ6] [RQ7]
        else $error("instruction run without DTR byte");
    pair_match_a: assert property (cmd_go && mode != MODE_PLAY |-> rx_byte == first_byte) // [RQ13]
        else $error("unmatched pair executed");
    cell_set_a: assert property ( // [RQ2]
        cells inside {7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h1E, 7'h3C})
        else $error("illegal cell count");
    cfg_idle_a: assert property ($changed(cells) |-> $past(mode) == MODE_IDLE) // [RQ18]
        else $error("cell count changed while busy");
    silence_end_a: assert property ( // [RQ3]
        mode == MODE_REC && !audio_present && sil_cnt == 32'(SIL_CYC - 1) |=> mode == MODE_IDLE)
        else $error("recording outlived silence");
    cell_full_a: assert property (mode == MODE_REC |-> elapsed < cap) // [RQ4]
        else $error("recording past cell share");
    one_src_a: assert property (!(play_active && out_ext_sel)) // [RQ11]
        else $error("two sources on low-level output");
    spk_load_a: assert property ( // [RQ10]
        cmd_go && is_spk |=> ##1 speaker_sel == $past(rx_byte[5:0], 2))
        else $error("speaker select not loaded");
    ignore_a: assert property ( // [RQ17]
        cmd_go && !cmd_ok |=> $stable(speaker_sel) && $stable(mode) && $stable(cells))
        else $error("unknown code changed state");
    play_go_a: assert property (cmd_go && is_play |=> mode == MODE_PLAY ##1 play_active) // [RQ9]
        else $error("play did not start");
    stat_len_a: assert property (gnt[0] |=> resp_n == 3'h4 && resp[0] == OP_STATUS) // [RQ16]
        else $error("status answer malformed");
    ans_go_a: assert property (resp_n != 3'h0 && !tx_busy |=> tx_busy) // [RQ8]
        else $error("answer byte not sent");

    rec_done_c: cover property (rec_end);
    repeat_c: cover property (play_hit && rep_left != 5'h00);
    status_c: cover property (cmd_go && is_stat);
    mismatch_c: cover property (mism);
endmodule // sacc_top
`default_nettype wire

//--- src/sacc_pkg.sv
package sacc_pkg;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD;
    localparam int SEC_CYCLES = CLK_HZ;
    localparam int SILENCE_SEC = 2;
    localparam int SILENCE_CYCLES = SILENCE_SEC * CLK_HZ;
    localparam int PAIR_TIMEOUT_MS = 500;
    localparam int PAIR_CYCLES = PAIR_TIMEOUT_MS * (CLK_HZ / 1000);
    // ****************************************************
    // Audio store
    // ****************************************************
    localparam int STORE_SEC = 240;
    localparam logic [6:0] DEF_CELLS = 7'h08;
    // ****************************************************
    // Instruction and response codes
    // ****************************************************
    localparam logic [7:0] OP_EXT_OFF = 8'h00;
    localparam logic [7:0] OP_ONE_CELL = 8'h03;
    localparam logic [7:0] OP_STOP = 8'h1F;
    localparam logic [7:0] OP_EXT_ON = 8'h20;
    localparam logic [7:0] OP_STATUS = 8'h40;
    localparam logic [7:0] RSP_REC_DONE = 8'h7E;
    localparam logic [7:0] RSP_MISMATCH = 8'h7F;
    localparam logic [7:0] RSP_TIMEOUT = 8'h40;
    localparam logic [7:0] RSP_PLAY_START = 8'h80;
    localparam logic [7:0] RSP_PLAY_DONE = 8'h81;
    // ****************************************************
    // Registers
    // ****************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam int IRQ_CMD = 0;
    localparam int IRQ_REC = 1;
    localparam int IRQ_PLAY = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_W = 4;
    localparam logic CTRL_RST = 1'b1;
    typedef enum logic [1:0] {MODE_IDLE, MODE_REC, MODE_PLAY} sacc_mode_type;
endpackage

//--- src/sacc_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_uart_rx import sacc_pkg::*; #(
    parameter int CYC = BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rxd,
    output logic [7:0] data,
    output logic valid
);
    logic rx_meta;
    logic rx_s;
    logic busy;
    logic [31:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
        end else begin
            rx_meta <= rxd;
            rx_s <= rx_meta;
        end
    end

    // Start, eight data bits LSB first, one stop bit, no parity [RQ14]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 32'h0;
            bitn <= 4'h0;
            sh <= 8'h00;
            data <= 8'h00;
            valid <= 1'b0;
        end else begin
            valid <= 1'b0;
            if (!busy) begin
                if (!rx_s) begin
                    busy <= 1'b1;
                    cnt <= 32'(CYC / 2);
                    bitn <= 4'h0;
                end
            end else if (cnt != 32'h0) begin
                cnt <= cnt - 32'h1;
            end else begin
                cnt <= 32'(CYC - 1);
                bitn <= bitn + 4'h1;
                if (bitn == 4'h0) begin
                    // Glitch shorter than half a bit
                    if (rx_s) busy <= 1'b0;
                end else if (bitn <= 4'h8) begin
                    sh <= {rx_s, sh[7:1]};
                end else begin
                    busy <= 1'b0;
                    if (rx_s) begin
                        data <= sh;
                        valid <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // sacc_uart_rx
`default_nettype wire

//--- src/sacc_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_uart_tx import sacc_pkg::*; #(
    parameter int CYC = BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic txd
);
    logic [9:0] sh;
    logic [31:0] cnt;
    logic [3:0] n;

    // One byte per frame, stop bit last [RQ8] [RQ14]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            txd <= 1'b1;
            sh <= 10'h3FF;
            cnt <= 32'h0;
            n <= 4'h0;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                sh <= {1'b1, data, 1'b0};
                n <= 4'h0;
                cnt <= 32'h0;
            end
        end else if (cnt != 32'h0) begin
            cnt <= cnt - 32'h1;
        end else if (n == 4'hA) begin
            busy <= 1'b0;
        end else begin
            txd <= sh[0];
            sh <= {1'b1, sh[9:1]};
            n <= n + 4'h1;
            cnt <= 32'(CYC - 1);
        end
    end
endmodule // sacc_uart_tx
`default_nettype wire

//--- test/sacc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host serial end
// ****************
module sacc_host_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    // 8N1, LSB first, one byte per instruction
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask
    // Mid-bit sampling, so edge jitter of a cycle is harmless
    always begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        rx_q.push_back(sh);
    end
endmodule // sacc_host_model
`default_nettype wire

//--- test/tb_serial_audio_cell_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_audio_cell_controller import sacc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic host_rxd, host_dtr, host_txd, passthrough_txd, audio_present;
    logic play_active, record_active, out_ext_sel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [5:0] speaker_sel, active_cell;
    int n_errors = 0;
    int n_checks = 0;
    // ****************
    // Instances
    // ****************
    sacc_top #(.SEC_CYC(100), .SIL_CYC(200), .PAIR_CYC(5000), .BIT_CYC(16)) sacc_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .host_rxd(host_rxd), .host_dtr(host_dtr), .host_txd(host_txd),
        .passthrough_txd(passthrough_txd), .audio_present(audio_present),
        .speaker_sel(speaker_sel), .play_active(play_active), .record_active(record_active),
        .out_ext_sel(out_ext_sel), .active_cell(active_cell));
    sacc_host_model #(.BIT_CYC(16)) host (.clk(pclk), .txd(host_txd), .rxd(host_rxd));
    sacc_host_model #(.BIT_CYC(16)) pt (.clk(pclk), .txd(passthrough_txd), .rxd());
    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pair(input logic [7:0] b);
        host.send(b);
        host.send(b);
    endtask
    task automatic rx(input logic [7:0] b);
        for (int i = 0; i < 9000 && host.rx_q.size() == 0; i++) @(posedge pclk);
        chk(host.rx_q.size() != 0 ? {24'h0, host.rx_q.pop_front()} : 32'h100, b);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        apb(1'b0, OFS_STATE, 32'h0);
        chk(r, 32'h00080000);
        apb(1'b0, 8'h14, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, OFS_IRQ_EN, 32'hF);
        $display("regs done");
    endtask
    task automatic t_cmds();
        host_dtr <= 1'b1;
        pair(8'hC5);
        rx(8'hC5);
        chk(speaker_sel, 6'h05);
        host.send(8'hC1);
        host.send(8'hC2);
        rx(RSP_MISMATCH);
        host.send(8'hC3);
        rx(RSP_TIMEOUT);
        chk(speaker_sel, 6'h05);
        pair(OP_STATUS);
        rx(8'h40);
        rx(8'h05);
        rx(8'h08);
        rx(8'h00);
        pair(8'h05);
        repeat (300) @(posedge pclk);
        chk(host.rx_q.size(), 0);
        $display("cmds done");
    endtask
    task automatic t_pass();
        host_dtr <= 1'b0;
        pair(8'hC0);
        repeat (20) @(posedge pclk);
        chk(pt.rx_q.size(), 2);
        chk(pt.rx_q.pop_front(), 8'hC0);
        chk(speaker_sel, 6'h05);
        $display("pass done");
    endtask
    task automatic t_audio();
        host_dtr <= 1'b1;
        audio_present <= 1'b1;
        pair(8'h1E);
        rx(8'h1E);
        apb(1'b0, OFS_STATE, 32'h0);
        chk(r[22:16], 7'h3C);
        pair(8'h82);
        chk(record_active, 1'b1);
        rx(8'h82);
        rx(RSP_REC_DONE);
        audio_present <= 1'b0;
        pair(8'h81);
        rx(8'h81);
        rx(RSP_REC_DONE);
        chk(record_active, 1'b0);
        pair(8'h41);
        chk({play_active, active_cell}, 7'h41);
        rx(8'h41);
        rx(RSP_PLAY_START);
        rx(RSP_PLAY_DONE);
        pair(8'h42);
        rx(8'h42);
        host.send(8'h21);
        rx(RSP_PLAY_START);
        rx(8'h21);
        chk(play_active, 1'b1);
        rx(RSP_PLAY_DONE);
        pair(OP_EXT_ON);
        rx(OP_EXT_ON);
        chk({play_active, out_ext_sel}, 2'b01);
        $display("audio done");
    endtask
    task automatic t_irq();
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(r, 32'hF);
        chk(irq, 1'b1);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, OFS_IRQ_CLR, 32'hF);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(r, 32'h0);
        $display("irq done");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, host_dtr, audio_present} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cmds();
        t_pass();
        t_audio();
        t_irq();
        complete_run();
    end
    // Hang guard, well above the longest expected run
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
endmodule // tb_serial_audio_cell_controller
`default_nettype wire
